// >>> src/uhc_cmd_sts.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "uhc_cfg.svh"

// What this block does
// - park enable resets to one and is writable when park is advertised, else zero read-only
// - park count resets to three, writable when advertised, else zero read-only
// - at most park-count successive transactions from one high-speed queue head
// - light reset reads one until done, keeps ports out of reset
// - doorbell sets async-advance status after eviction and clears itself in the same cycle
// - async-advance raises interrupt at next threshold when its enable is set
// - async enable resets zero; one lets the async schedule be fetched
// - periodic enable resets zero; one lets the periodic schedule be fetched
// - frame list size resets 00b, writable only if programmable lists advertised
// - controller reset aborts transactions and reinitialises internal state
// - controller reset restores operational and port registers, hands ports back
// - device clears controller reset bit when done; writing zero cannot end it
// - run bit resets zero; after clearing, halt within 16 micro-frames
// - async status resets zero and follows the real async schedule state
// - periodic status resets zero and follows the real periodic schedule state
// - reclamation flag is read-only, resets zero, tracks async emptiness
// - halted resets one, zero while running, set once execution stopped
// - host system error sets status bit 4 and clears the run bit
module uhc_cmd_sts #(
    parameter bit PARK_CAP = 1'b1,
    parameter bit PROG_FLS = 1'b1,
    parameter bit LIGHT_RST_IMPL = 1'b1
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire uhc_pkg::uhc_sched_evt_s evt_in,
    output uhc_pkg::uhc_sched_ctl_s ctl_out,
    output logic port_reset_out,
    output logic irq_out
);
    import uhc_pkg::*;

    localparam logic [10:0] UF_LAST = 11'(`UHC_UFRAME_CYC - 1);
    localparam logic [4:0] HALT_UF = 5'(`UHC_HALT_UFRAMES);

    uhc_state_s s_q;
    uhc_state_s s_d;

    // write-one-to-clear helper shared by both sticky flags
    function automatic logic w1c(input logic cur, input logic set, input logic clr);
        w1c = set | (cur & ~clr);
    endfunction : w1c

    logic wr_cmd;
    logic wr_sts;
    logic wr_inen;
    logic uf_tick;

    assign wr_cmd = wr_in && (addr_in == `UHC_ADDR_CMD);
    assign wr_sts = wr_in && (addr_in == `UHC_ADDR_STS);
    assign wr_inen = wr_in && (addr_in == `UHC_ADDR_INTEN);
    assign uf_tick = (s_q.uf_cnt == UF_LAST);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.uf_cnt = uf_tick ? 11'h000 : s_q.uf_cnt + 11'h001;
        // software writes to the command register
        if (wr_cmd)
        begin
            s_d.run = wdata_in[`UHC_CMD_RUN];
            s_d.async_en = wdata_in[`UHC_CMD_ASE];
            s_d.periodic_en = wdata_in[`UHC_CMD_PSE];
            if (PROG_FLS)
            begin
                s_d.fls = wdata_in[`UHC_CMD_FLS_HI:`UHC_CMD_FLS_LO];
            end
            if (PARK_CAP)
            begin
                s_d.park_en = wdata_in[`UHC_CMD_PARK];
                s_d.park_cnt = wdata_in[`UHC_CMD_PCNT_HI:`UHC_CMD_PCNT_LO];
            end
            // ring doorbell only by writing one
            if (wdata_in[`UHC_CMD_DOORBELL])
            begin
                s_d.doorbell = 1'b1;
            end
            if (LIGHT_RST_IMPL && wdata_in[`UHC_CMD_LRST])
            begin
                s_d.light_rst = 1'b1;
                s_d.state = UHC_RESETTING;
                s_d.rst_cnt = `UHC_RST_CYC;
            end
            // a zero write cannot end a running reset
            if (wdata_in[`UHC_CMD_HCRST])
            begin
                s_d.state = UHC_RESETTING;
                s_d.rst_cnt = `UHC_RST_CYC;
            end
        end
        if (wr_inen)
        begin
            s_d.iaa_en = wdata_in[`UHC_INTEN_IAA];
        end
        // eviction sets status, doorbell clears after it
        // clear by writing one, a new event wins
        s_d.iaa = w1c(s_q.iaa, s_q.doorbell && evt_in.evicted,
                      wr_sts && wdata_in[`UHC_STS_IAA]);
        if (s_q.doorbell && evt_in.evicted)
        begin
            s_d.doorbell = 1'b0;
        end
        // system error sets flag and stops the schedule
        s_d.hse = w1c(s_q.hse, evt_in.sys_err, wr_sts && wdata_in[`UHC_STS_HSE]);
        if (evt_in.sys_err)
        begin
            s_d.run = 1'b0;
        end
        if (evt_in.async_empty)
        begin
            s_d.reclaim = 1'b0;
        end
        else if (evt_in.async_nonempty)
        begin
            s_d.reclaim = 1'b1;
        end
        // park budget per high-speed queue head
        if (evt_in.txn_done && evt_in.from_hs_qh && s_q.park_en)
        begin
            if (s_q.park_left > 2'h1)
            begin
                s_d.park_left = s_q.park_left - 2'h1;
                s_d.park_stay = 1'b1;
            end
            else
            begin
                s_d.park_left = s_q.park_cnt;
                s_d.park_stay = 1'b0;
            end
        end
        else if (evt_in.txn_done)
        begin
            s_d.park_left = s_q.park_cnt;
            s_d.park_stay = s_q.park_en && (s_q.park_cnt > 2'h1);
        end
        // interrupt threshold ticks every eight micro-frames
        s_d.irq = 1'b0;
        if (uf_tick)
        begin
            if (s_q.thr_uf == `UHC_INTTHR_UFR - 5'h01)
            begin
                s_d.thr_uf = 5'h00;
                s_d.irq = s_q.iaa && s_q.iaa_en;
            end
            else
            begin
                s_d.thr_uf = s_q.thr_uf + 5'h01;
            end
        end
        // controller state machine
        case (s_q.state)
            UHC_HALTED:
            begin
                if (s_d.run && s_d.state == UHC_HALTED)
                begin
                    s_d.state = UHC_RUNNING;
                end
            end
            UHC_RUNNING:
            begin
                // schedule status follows enables while running
                s_d.async_sts = s_q.async_en;
                s_d.periodic_sts = s_q.periodic_en;
                if (!s_d.run && s_d.state == UHC_RUNNING)
                begin
                    s_d.state = UHC_STOPPING;
                    s_d.halt_uf = 5'h00;
                end
            end
            UHC_STOPPING:
            begin
                // pipeline drains, forced halt at the limit
                if (uf_tick)
                begin
                    s_d.halt_uf = s_q.halt_uf + 5'h01;
                end
                if (s_d.state == UHC_STOPPING &&
                    (evt_in.idle || s_q.halt_uf == HALT_UF - 5'h01))
                begin
                    s_d.state = UHC_HALTED;
                    s_d.async_sts = 1'b0;
                    s_d.periodic_sts = 1'b0;
                end
            end
            UHC_RESETTING:
            begin
                if (s_q.rst_cnt == 8'h00)
                begin
                    // internal state back to initial values
                    s_d.state = UHC_HALTED;
                    s_d.run = 1'b0;
                    s_d.async_en = 1'b0;
                    s_d.periodic_en = 1'b0;
                    s_d.park_en = PARK_CAP;
                    s_d.park_cnt = PARK_CAP ? `UHC_PCNT_RST : `UHC_PCNT_ZERO;
                    s_d.fls = `UHC_FLS_RST;
                    s_d.doorbell = 1'b0;
                    s_d.iaa = 1'b0;
                    s_d.hse = 1'b0;
                    s_d.reclaim = 1'b0;
                    s_d.async_sts = 1'b0;
                    s_d.periodic_sts = 1'b0;
                    s_d.iaa_en = 1'b0;
                    s_d.park_left = s_d.park_cnt;
                    s_d.park_stay = 1'b0;
                    s_d.light_rst = 1'b0;
                end
                else
                begin
                    s_d.rst_cnt = s_q.rst_cnt - 8'h01;
                    s_d.run = 1'b0;
                end
            end
            default:
            begin
                s_d.state = UHC_HALTED;
            end
        endcase
        // read data, valid in the cycle after the read strobe
        s_d.rdata = 32'h0000_0000;
        if (rd_in)
        begin
            case (addr_in)
                `UHC_ADDR_CMD:
                begin
                    s_d.rdata[`UHC_CMD_RUN] = s_q.run;
                    s_d.rdata[`UHC_CMD_HCRST] = (s_q.state == UHC_RESETTING) && !s_q.light_rst;
                    s_d.rdata[`UHC_CMD_FLS_HI:`UHC_CMD_FLS_LO] = s_q.fls;
                    s_d.rdata[`UHC_CMD_PSE] = s_q.periodic_en;
                    s_d.rdata[`UHC_CMD_ASE] = s_q.async_en;
                    s_d.rdata[`UHC_CMD_DOORBELL] = s_q.doorbell;
                    s_d.rdata[`UHC_CMD_LRST] = s_q.light_rst;
                    s_d.rdata[`UHC_CMD_PCNT_HI:`UHC_CMD_PCNT_LO] = s_q.park_cnt;
                    s_d.rdata[`UHC_CMD_PARK] = s_q.park_en;
                end
                `UHC_ADDR_STS:
                begin
                    s_d.rdata[`UHC_STS_HSE] = s_q.hse;
                    s_d.rdata[`UHC_STS_IAA] = s_q.iaa;
                    // halted only outside running and stopping
                    s_d.rdata[`UHC_STS_HALT] = (s_q.state == UHC_HALTED) ||
                                               (s_q.state == UHC_RESETTING);
                    s_d.rdata[`UHC_STS_RECL] = s_q.reclaim;
                    s_d.rdata[`UHC_STS_PSS] = s_q.periodic_sts;
                    s_d.rdata[`UHC_STS_ASS] = s_q.async_sts;
                end
                `UHC_ADDR_INTEN:
                begin
                    s_d.rdata[`UHC_INTEN_IAA] = s_q.iaa_en;
                end
                default:
                begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s_q <= '0;
            s_q.state <= UHC_HALTED;
            s_q.park_en <= PARK_CAP;
            s_q.park_cnt <= PARK_CAP ? `UHC_PCNT_RST : `UHC_PCNT_ZERO;
            s_q.park_left <= PARK_CAP ? `UHC_PCNT_RST : `UHC_PCNT_ZERO;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs; run only reaches the engine while really executing
    assign rdata_out = s_q.rdata;
    assign irq_out = s_q.irq;
    // full reset also resets ports, light reset keeps them
    assign port_reset_out = (s_q.state == UHC_RESETTING) && !s_q.light_rst;
    assign ctl_out.run = (s_q.state == UHC_RUNNING);
    assign ctl_out.async_en = s_q.async_sts && s_q.state == UHC_RUNNING;
    assign ctl_out.periodic_en = s_q.periodic_sts && s_q.state == UHC_RUNNING;
    assign ctl_out.park_en = s_q.park_en && s_q.park_stay;
    assign ctl_out.park_cnt = s_q.park_cnt;
    assign ctl_out.frame_list_size = s_q.fls;
    assign ctl_out.abort = (s_q.state == UHC_RESETTING);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence ring_s;
        wr_cmd && wdata_in[`UHC_CMD_DOORBELL];
    endsequence

    halt_not_run_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_q.state == UHC_RUNNING |-> !(ctl_out.abort))
        else $error("running while aborting");
    stop_bound_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_q.state == UHC_STOPPING |-> s_q.halt_uf < HALT_UF)
        else $error("halt took too long");
    hse_stop_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        evt_in.sys_err && !wr_cmd |=> s_q.hse && !s_q.run)
        else $error("system error not handled");
    iaa_set_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_q.doorbell && evt_in.evicted |=> s_q.iaa && !s_q.doorbell)
        else $error("doorbell handshake broken");
    ring_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ring_s |=> s_q.doorbell || s_q.state == UHC_RESETTING)
        else $error("doorbell not latched");
    w1c_keep_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_q.hse && !(wr_sts && wdata_in[`UHC_STS_HSE]) && s_q.state != UHC_RESETTING
        |=> s_q.hse)
        else $error("error flag lost");
    park_ro_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !PARK_CAP |-> !s_q.park_en && s_q.park_cnt == `UHC_PCNT_ZERO)
        else $error("park bits writable without capability");
    fls_ro_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !PROG_FLS |-> s_q.fls == `UHC_FLS_RST)
        else $error("frame list size writable");
    rst_done_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_q.state == UHC_RESETTING && s_q.rst_cnt != 8'h00 |=> s_q.state == UHC_RESETTING)
        else $error("reset ended early");

    // threshold tick: the last micro-frame of an interrupt interval
    sequence thr_s;
        uf_tick && s_q.thr_uf == `UHC_INTTHR_UFR - 5'h01;
    endsequence

    irq_thr_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        thr_s ##0 (s_q.iaa && s_q.iaa_en) |=> irq_out)
        else $error("threshold passed without interrupt");
    irq_quiet_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !(s_q.iaa && s_q.iaa_en) |=> !irq_out)
        else $error("interrupt without enabled cause");
    halt_read_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        rd_in && addr_in == `UHC_ADDR_STS && s_q.run && s_q.state != UHC_RESETTING
        |=> !rdata_out[`UHC_STS_HALT])
        else $error("halted shown while running");
    park_limit_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        evt_in.txn_done && evt_in.from_hs_qh && s_q.park_en && s_q.park_left <= 2'h1
        |=> !ctl_out.park_en)
        else $error("park budget overrun");
    rst_abort_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_q.state == UHC_RESETTING |-> ctl_out.abort && !ctl_out.run)
        else $error("schedule not aborted in reset");
    rst_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_q.state == UHC_RESETTING && s_q.rst_cnt == 8'h00
        |=> s_q.state == UHC_HALTED && !s_q.light_rst)
        else $error("reset bit not cleared when done");

endmodule : uhc_cmd_sts

// >>> src/uhc_cfg.svh
`ifndef UHC_CFG_SVH
`define UHC_CFG_SVH

// register map, byte addresses on the plain port
`define UHC_ADDR_CMD 8'h00
`define UHC_ADDR_STS 8'h04
`define UHC_ADDR_INTEN 8'h08
// command field positions
`define UHC_CMD_RUN 0
`define UHC_CMD_HCRST 1
`define UHC_CMD_FLS_LO 2
`define UHC_CMD_FLS_HI 3
`define UHC_CMD_PSE 4
`define UHC_CMD_ASE 5
`define UHC_CMD_DOORBELL 6
`define UHC_CMD_LRST 7
`define UHC_CMD_PCNT_LO 8
`define UHC_CMD_PCNT_HI 9
`define UHC_CMD_PARK 11
// status field positions
`define UHC_STS_HSE 4
`define UHC_STS_IAA 5
`define UHC_STS_HALT 12
`define UHC_STS_RECL 13
`define UHC_STS_PSS 14
`define UHC_STS_ASS 15
// interrupt enable bit for async advance
`define UHC_INTEN_IAA 5
// reset values
`define UHC_PCNT_RST 2'h3
`define UHC_PCNT_ZERO 2'h0
`define UHC_FLS_RST 2'h0
// timing: 16 micro-frames of 125 us at 100 ns per cycle
`define UHC_CLK_NS 100
`define UHC_UFRAME_NS 125000
`define UHC_UFRAME_CYC (`UHC_UFRAME_NS / `UHC_CLK_NS)
`define UHC_HALT_UFRAMES 16
// reset sequence length in clock cycles
`define UHC_RST_CYC 8'h10
// interrupt interval in micro-frames
`define UHC_INTTHR_UFR 5'h08

`endif

// >>> src/uhc_pkg.sv
package uhc_pkg;

    typedef enum logic [3:0] {
        UHC_HALTED = 4'b0001,
        UHC_RUNNING = 4'b0010,
        UHC_STOPPING = 4'b0100,
        UHC_RESETTING = 4'b1000
    } uhc_state_e;

    // schedule engine view of the controller
    typedef struct packed {
        logic run;
        logic async_en;
        logic periodic_en;
        logic park_en;
        logic [1:0] park_cnt;
        logic [1:0] frame_list_size;
        logic abort;
    } uhc_sched_ctl_s;

    typedef struct packed {
        logic txn_done;
        logic from_hs_qh;
        logic evicted;
        logic async_empty;
        logic async_nonempty;
        logic sys_err;
        logic idle;
    } uhc_sched_evt_s;

    typedef struct packed {
        uhc_state_e state;
        logic run;
        logic async_en;
        logic periodic_en;
        logic park_en;
        logic [1:0] park_cnt;
        logic [1:0] fls;
        logic doorbell;
        logic light_rst;
        logic iaa;
        logic hse;
        logic reclaim;
        logic async_sts;
        logic periodic_sts;
        logic iaa_en;
        logic [1:0] park_left;
        logic park_stay;
        logic [7:0] rst_cnt;
        logic [10:0] uf_cnt;
        logic [4:0] halt_uf;
        logic [4:0] thr_uf;
        logic irq;
        logic [31:0] rdata;
    } uhc_state_s;

endpackage : uhc_pkg

// >>> tb/uhc_sched_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// schedule engine stand-in
// ----------------------------------------
// slow_in stretches the wind-down so that the halt wait is really exercised
// hang_in never reports idle, so only the design's own halt limit ends a stop
module uhc_sched_model
    import uhc_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire uhc_pkg::uhc_sched_ctl_s ctl_in,
    input wire logic slow_in,
    input wire logic hang_in,
    input wire logic evict_in,
    input wire logic err_in,
    input wire logic empty_in,
    output uhc_pkg::uhc_sched_evt_s evt_out
);
    logic [5:0] stop_cnt_q;
    logic [2:0] evict_dly_q;
    logic [5:0] limit;

    assign limit = slow_in ? 6'h28 : 6'h02;

    // events follow the control word one cycle later, like a real engine
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            evt_out <= '0;
            stop_cnt_q <= 6'h00;
            evict_dly_q <= 3'h0;
        end
        else
        begin
            evt_out.txn_done <= ctl_in.run & ~evt_out.txn_done;
            evt_out.from_hs_qh <= ctl_in.run & ctl_in.async_en;
            evict_dly_q <= {evict_dly_q[1:0], evict_in};
            evt_out.evicted <= evict_dly_q[2];
            evt_out.async_nonempty <= ctl_in.run & ctl_in.async_en & ~empty_in;
            evt_out.async_empty <= empty_in;
            evt_out.sys_err <= err_in;
            if (ctl_in.run || ctl_in.abort)
                stop_cnt_q <= 6'h00;
            else if (stop_cnt_q != limit)
                stop_cnt_q <= stop_cnt_q + 6'h01;
            evt_out.idle <= !ctl_in.run && !hang_in && (stop_cnt_q == limit);
        end
    end
endmodule : uhc_sched_model

// >>> tb/usb_host_command_status_ctrl_tb.sv
`timescale 1ns/1ps

module usb_host_command_status_ctrl_tb;
    import uhc_pkg::*;
    logic clk_in, arst_n_in, wr_in, rd_in, slow, hang, evict, err, empty, port_reset, irq;
    logic [7:0] addr_in;
    logic [31:0] wdata_in, rdata, d;
    uhc_sched_evt_s evt;
    uhc_sched_ctl_s ctl;
    int miscompares, comparisons, cmd_m, sts_m, n, run_len, max_len;

    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    uhc_cmd_sts dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .evt_in(evt),
        .ctl_out(ctl), .port_reset_out(port_reset), .irq_out(irq));

    uhc_sched_model model (.clk_in(clk_in), .arst_n_in(arst_n_in), .ctl_in(ctl),
        .slow_in(slow), .hang_in(hang), .evict_in(evict), .err_in(err), .empty_in(empty),
        .evt_out(evt));

    // ----------------------------------------
    // bus tasks and comparison
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // the reference copy of the command and status registers follows every write to them
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        if (a == 8'h00)
            cmd_m = (cmd_m & ~32'h00000B3D) | (v & 32'h00000B3D) | (v & 32'h00000040);
        if (a == 8'h04)
            sts_m = sts_m & ~(v & 32'h00000030);
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata;
        chk(what, d & m, exp & m);
    endtask : rdc

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
    endtask : cyc

    // polls halted; a stop must finish inside 16 micro-frames of 1250 cycles
    task automatic wait_halt();
        n = 0;
        d = 32'h00000000;
        while (d[12] !== 1'b1 && n < 25000)
        begin
            rdc("poll", 8'h04, 32'h00000000, 32'h00000000);
            n += 2;
        end
        chk("halt time", 32'(n <= 20000), 32'h00000001);
    endtask : wait_halt

    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    // watchdog sized well above the longest path of the sequence
    initial
    begin
        #6000000;
        miscompares++;
        $display("watchdog expired");
        finish_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {wr_in, rd_in, slow, hang, evict, err, empty, arst_n_in} = '0;
        addr_in = 8'h00;
        wdata_in = 32'h00000000;
        miscompares = 0;
        comparisons = 0;
        cmd_m = 32'h00000B00;
        sts_m = 32'h00001000;
        repeat (12) @(posedge clk_in);
        arst_n_in <= 1'b1;
        void'($urandom(32'hf05cbd62));
        rdc("cmd reset", 8'h00, 32'hFFFFFFFF, cmd_m);
        rdc("sts reset", 8'h04, 32'hFFFFFFFF, sts_m);
        rdc("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h00000000);
        chk("park cnt out", 32'(ctl.park_cnt), 32'h00000003);
        for (int i = 0; i < 4; i++)
        begin
            d = $urandom & ~32'h000000C3;
            if (d[3:2] == 2'h3)
                d[3:2] = 2'h2;
            if (d[9:8] == 2'h0)
                d[9:8] = 2'h1;
            wr(8'h00, d);
            rdc("cmd cfg", 8'h00, 32'hFFFFFFFF, cmd_m);
            chk("fls out", 32'(ctl.frame_list_size), 32'((cmd_m >> 2) & 3));
            chk("pcnt out", 32'(ctl.park_cnt), 32'((cmd_m >> 8) & 3));
        end
        $display("test reset_config done");
        wr(8'h00, 32'h00000B31); // set only while halted
        cyc(6);
        chk("run out", 32'(ctl.run), 32'h00000001);
        sts_m = 32'h0000E000;
        rdc("sts run", 8'h04, 32'hFFFFFFFF, sts_m);
        chk("sched out", 32'({ctl.async_en, ctl.periodic_en}), 32'h00000003);
        // park count three: a stay spans at most two transactions of two cycles each
        run_len = 0;
        max_len = 0;
        repeat (60)
        begin
            @(posedge clk_in);
            #1;
            run_len = ctl.park_en ? run_len + 1 : 0;
            if (run_len > max_len)
                max_len = run_len;
        end
        chk("park streak", 32'(max_len > 0 && max_len <= 4), 32'h00000001);
        wr(8'h08, 32'h00000020);
        wr(8'h00, 32'h00000B71); // async enabled
        rdc("bell up", 8'h00, 32'hFFFFFFFF, cmd_m);
        @(posedge clk_in) evict <= 1'b1;
        @(posedge clk_in) evict <= 1'b0;
        cyc(8);
        cmd_m &= ~32'h00000040;
        sts_m |= 32'h00000020;
        rdc("bell cmd", 8'h00, 32'hFFFFFFFF, cmd_m);
        rdc("bell sts", 8'h04, 32'hFFFFFFFF, sts_m);
        n = 0;
        while (irq !== 1'b1 && n < 12000)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk("irq", 32'(irq), 32'h00000001);
        wr(8'h04, 32'h00000020);
        rdc("iaa clr", 8'h04, 32'hFFFFFFFF, sts_m);
        $display("test run_doorbell done");
        slow <= 1'b1;
        wr(8'h00, 32'h00000B30);
        rdc("still busy", 8'h04, 32'h00001000, 32'h00000000);
        wait_halt();
        sts_m = (sts_m & ~32'h0000C000) | 32'h00001000;
        rdc("sts halt", 8'h04, 32'h0000D030, sts_m);
        chk("sched off", 32'({ctl.run, ctl.async_en, ctl.periodic_en}), 32'h00000000);
        empty <= 1'b1;
        cyc(4);
        sts_m &= ~32'h00002000;
        rdc("recl clr", 8'h04, 32'hFFFFFFFF, sts_m);
        $display("test stop done");
        // engine never reports idle here, so the stop ends on the design's own limit
        slow <= 1'b0;
        hang <= 1'b1;
        wr(8'h00, 32'h00000B31);
        cyc(4);
        @(posedge clk_in) err <= 1'b1;
        @(posedge clk_in) err <= 1'b0;
        cyc(4);
        cmd_m &= ~32'h00000001;
        sts_m = 32'h00000010;
        rdc("err run", 8'h00, 32'h00000001, cmd_m);
        wait_halt();
        hang <= 1'b0;
        sts_m |= 32'h00001000;
        rdc("err sts", 8'h04, 32'hFFFFFFFF, sts_m);
        wr(8'h04, 32'h00000000);
        rdc("w0 keeps", 8'h04, 32'hFFFFFFFF, sts_m);
        wr(8'h04, 32'h00000010);
        rdc("w1 clears", 8'h04, 32'hFFFFFFFF, sts_m);
        $display("test sys_error done");
        wr(8'h00, 32'h00000A18);
        wr(8'h00, 32'h00000A1A); // halted
        cyc(1);
        chk("port reset", 32'(port_reset), 32'h00000001);
        chk("abort", 32'(ctl.abort), 32'h00000001);
        rdc("rst bit", 8'h00, 32'h00000002, 32'h00000002);
        wr(8'h00, 32'h00000A18);
        rdc("rst held", 8'h00, 32'h00000002, 32'h00000002);
        cyc(30);
        cmd_m = 32'h00000B00;
        sts_m = 32'h00001000;
        rdc("cmd after", 8'h00, 32'hFFFFFFFF, cmd_m);
        rdc("sts after", 8'h04, 32'hFFFFFFFF, sts_m);
        rdc("inten after", 8'h08, 32'hFFFFFFFF, 32'h00000000);
        chk("port rel", 32'(port_reset), 32'h00000000);
        chk("abort rel", 32'(ctl.abort), 32'h00000000);
        $display("test ctrl_reset done");
        wr(8'h00, 32'h00000A18);
        wr(8'h00, 32'h00000A98);
        rdc("light bit", 8'h00, 32'h00000080, 32'h00000080);
        chk("light ports", 32'(port_reset), 32'h00000000);
        cyc(30);
        rdc("light done", 8'h00, 32'hFFFFFFFF, 32'h00000B00);
        rdc("light sts", 8'h04, 32'hFFFFFFFF, 32'h00001000);
        $display("test light_reset done");
        finish_test();
    end
endmodule : usb_host_command_status_ctrl_tb
